//--- srac_core.sv
// Purpose: smm ram window control, decode and configuration registers
// Assumes: one host request and one hub request per cycle at most
// Notes:   routing answers appear one cycle after the request
`timescale 1ns/10ps

// Behaviour
// - open, close and lock writes are ignored unless global enable is set.
// - open with lock clear shows smm dram to non-smm accesses.
// - close denies data references to all smm spaces; code still reaches dram.
// - lock clears open and freezes lock, open, global, high, top segment.
// - lock is set by a config write, cleared only by full reset.
// - global enable claims smm accesses to the a0000h window for dram.
// - global enable clear disables high window and top segment.
// - base segment field reads fixed 010.
// - compatible window is not remapped; denied accesses go to hub.
// - high window fedA0000h-fedbffffh remaps onto a0000h-bffffh.
// - extended range access outside smm sets violation; write 1 clears.
// - cacheable, first and second level bits always read 1.
// - global and top segment enable expose the 1 mbyte top segment.
// - control register at 60h resets to 02h.
// - extended register at 61h resets to 38h.
// - hub accesses to a0000h-bffffh are refused while smm space enabled.
module srac_core
    import srac_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire logic           cfg_wr,
    input  wire logic           cfg_rd,
    input  wire logic [7:0]     cfg_addr,
    input  wire logic [7:0]     cfg_wdata,
    output logic      [7:0]     cfg_rdata,
    output logic                cfg_rvalid,
    input  wire logic           host_valid,
    input  wire srac_host_req_t host_req,
    input  wire logic [31:0]    tseg_base,
    output logic                route_valid,
    output srac_route_t         route,
    input  wire logic           hub_valid,
    input  wire logic [31:0]    hub_addr,
    output logic                hub_refuse,
    output logic                hub_accept,
    output logic                smm_space_locked_out
);

    // ****************************************
    // register state
    // ****************************************
    logic smm_space_open;
    logic smm_space_closed;
    logic smm_space_locked;
    logic global_smm_ram_enable;
    logic high_window_enable_bit;
    logic top_segment_enable;
    logic extended_access_violation;

    logic wr_ctrl;
    logic wr_ext;
    logic ctrl_bits_live;
    logic lock_request;

    assign wr_ctrl        = cfg_wr && (cfg_addr == SRAC_CTRL_OFS);
    assign wr_ext         = cfg_wr && (cfg_addr == SRAC_EXT_OFS);
    assign ctrl_bits_live = global_smm_ram_enable;
    assign lock_request   = wr_ctrl && ctrl_bits_live
                            && cfg_wdata[SRAC_LOCK_BIT];

    // ****************************************
    // register read image
    // ****************************************
    function automatic logic [7:0] ctrl_image(
        input logic open_b,
        input logic close_b,
        input logic lock_b,
        input logic glob_b
    );
        logic [7:0] v;
        v                  = 8'h00;
        v[SRAC_OPEN_BIT]   = open_b;
        v[SRAC_CLOSE_BIT]  = close_b;
        v[SRAC_LOCK_BIT]   = lock_b;
        v[SRAC_GLOBAL_BIT] = glob_b;
        v[2:0]             = SRAC_BASE_SEG;
        return v;
    endfunction : ctrl_image

    function automatic logic [7:0] ext_image(
        input logic high_b,
        input logic viol_b,
        input logic tseg_b
    );
        logic [7:0] v;
        v                 = 8'h00;
        v[SRAC_HIGH_BIT]  = high_b;
        v[SRAC_VIOL_BIT]  = viol_b;
        v[SRAC_CACHE_BIT] = 1'b1;
        v[SRAC_L1_BIT]    = 1'b1;
        v[SRAC_L2_BIT]    = 1'b1;
        v[SRAC_TSEG_BIT]  = tseg_b;
        return v;
    endfunction : ext_image

    // ****************************************
    // global enable
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            global_smm_ram_enable <= SRAC_CTRL_RESET[SRAC_GLOBAL_BIT];
        else if (wr_ctrl && !smm_space_locked)
            global_smm_ram_enable <= cfg_wdata[SRAC_GLOBAL_BIT];
    end

    // ****************************************
    // lock, sticky until full reset
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            smm_space_locked <= SRAC_CTRL_RESET[SRAC_LOCK_BIT];
        else if (lock_request)
            smm_space_locked <= 1'b1;
    end

    // ****************************************
    // open
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            smm_space_open <= SRAC_CTRL_RESET[SRAC_OPEN_BIT];
        else if (smm_space_locked || lock_request)
            smm_space_open <= 1'b0;
        else if (wr_ctrl && ctrl_bits_live)
            smm_space_open <= cfg_wdata[SRAC_OPEN_BIT];
    end

    // ****************************************
    // close, stays writable under lock
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            smm_space_closed <= SRAC_CTRL_RESET[SRAC_CLOSE_BIT];
        else if (wr_ctrl && ctrl_bits_live)
            smm_space_closed <= cfg_wdata[SRAC_CLOSE_BIT];
    end

    // ****************************************
    // extended enables
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            high_window_enable_bit <= SRAC_EXT_RESET[SRAC_HIGH_BIT];
            top_segment_enable     <= SRAC_EXT_RESET[SRAC_TSEG_BIT];
        end
        else if (wr_ext && !smm_space_locked)
        begin
            high_window_enable_bit <= cfg_wdata[SRAC_HIGH_BIT];
            top_segment_enable     <= cfg_wdata[SRAC_TSEG_BIT];
        end
    end

    // ****************************************
    // window decode
    // ****************************************
    logic hit_compat;
    logic hit_high;
    logic hit_tseg;
    logic hub_hit_compat;

    srac_range_match #(.SIZE_BITS(SRAC_WIN_BITS)) u_match_compat (
        .addr (host_req.addr),
        .base (SRAC_COMPAT_BASE),
        .hit  (hit_compat)
    );

    srac_range_match #(.SIZE_BITS(SRAC_WIN_BITS)) u_match_high (
        .addr (host_req.addr),
        .base (SRAC_HIGH_BASE),
        .hit  (hit_high)
    );

    srac_range_match #(.SIZE_BITS(SRAC_TSEG_BITS)) u_match_tseg (
        .addr (host_req.addr),
        .base (tseg_base),
        .hit  (hit_tseg)
    );

    srac_range_match #(.SIZE_BITS(SRAC_WIN_BITS)) u_match_hub (
        .addr (hub_addr),
        .base (SRAC_COMPAT_BASE),
        .hit  (hub_hit_compat)
    );

    // ****************************************
    // access permission
    // ****************************************
    logic high_live;
    logic tseg_live;
    logic data_denied;
    logic smm_visible;

    assign high_live   = global_smm_ram_enable
                         && high_window_enable_bit;
    assign tseg_live   = global_smm_ram_enable
                         && top_segment_enable;
    // close beats open and smm decode for data
    assign data_denied = global_smm_ram_enable && smm_space_closed
                         && !host_req.code;
    assign smm_visible = global_smm_ram_enable && !data_denied
                         && (host_req.smm
                             || (smm_space_open
                                 && !smm_space_locked));

    // ****************************************
    // routing
    // ****************************************
    srac_route_t next_route;

    always_comb
    begin
        next_route           = '0;
        next_route.dram_addr = host_req.addr;
        if (hit_compat && global_smm_ram_enable)
        begin
            next_route.smm_hit = 1'b1;
            next_route.dram    = smm_visible;
            next_route.hub     = !smm_visible;
        end
        else if (hit_high && high_live)
        begin
            next_route.smm_hit   = 1'b1;
            next_route.dram      = smm_visible;
            next_route.hub       = !smm_visible;
            next_route.dram_addr = {SRAC_COMPAT_BASE[31:SRAC_WIN_BITS],
                                    host_req.addr[SRAC_WIN_BITS-1:0]};
        end
        else if (hit_tseg && tseg_live)
        begin
            next_route.smm_hit = 1'b1;
            next_route.dram    = smm_visible;
            next_route.hub     = !smm_visible;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            route_valid <= 1'b0;
            route       <= '0;
        end
        else
        begin
            route_valid <= host_valid;
            if (host_valid)
                route <= next_route;
        end
    end

    // ****************************************
    // extended range violation
    // ****************************************
    logic viol_set;
    logic viol_clear;

    assign viol_set   = host_valid && !host_req.smm
                        && ((hit_high && high_live)
                            || (hit_tseg && tseg_live));
    assign viol_clear = wr_ext && cfg_wdata[SRAC_VIOL_BIT];

    srac_sticky_flag u_viol (
        .clk   (clk),
        .rstn  (rstn),
        .set   (viol_set),
        .clear (viol_clear),
        .q     (extended_access_violation)
    );

    // ****************************************
    // hub side protection
    // ****************************************
    logic next_hub_refuse;

    assign next_hub_refuse = hub_valid && hub_hit_compat
                             && global_smm_ram_enable;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hub_refuse <= 1'b0;
            hub_accept <= 1'b0;
        end
        else
        begin
            hub_refuse <= next_hub_refuse;
            hub_accept <= hub_valid && !next_hub_refuse;
        end
    end

    // ****************************************
    // configuration read port
    // ****************************************
    logic [7:0] next_cfg_rdata;

    always_comb
    begin
        case (cfg_addr)
            SRAC_CTRL_OFS:
                next_cfg_rdata = ctrl_image(smm_space_open,
                                            smm_space_closed,
                                            smm_space_locked,
                                            global_smm_ram_enable);
            SRAC_EXT_OFS:
                next_cfg_rdata = ext_image(high_window_enable_bit,
                                           extended_access_violation,
                                           top_segment_enable);
            default:
                next_cfg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_rdata  <= 8'h00;
            cfg_rvalid <= 1'b0;
        end
        else
        begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd)
                cfg_rdata <= next_cfg_rdata;
        end
    end

    // ****************************************
    // lock indication for other config blocks
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            smm_space_locked_out <= 1'b0;
        else
            smm_space_locked_out <= smm_space_locked
                                    || lock_request;
    end

endmodule : srac_core

//--- srac_core_props.sv
// Purpose: port checks on srac_core
// Assumes: one clock, async active low reset
// Notes:   bound to every srac_core
`timescale 1ns/10ps
module srac_core_props
    import srac_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire logic           cfg_rd,
    input  wire logic           cfg_rvalid,
    input  wire logic           host_valid,
    input  wire srac_host_req_t host_req,
    input  wire logic           route_valid,
    input  wire srac_route_t    route,
    input  wire logic           hub_valid,
    input  wire logic [31:0]    hub_addr,
    input  wire logic           hub_refuse,
    input  wire logic           hub_accept,
    input  wire logic           smm_space_locked_out
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_cfg_rv;
        cfg_rd |=> cfg_rvalid;
    endproperty
    a_cfg_rv: assert property (p_cfg_rv)
        else $error("config read not answered");
    property p_route_v;
        host_valid |=> route_valid;
    endproperty
    a_route_v: assert property (p_route_v)
        else $error("host request not routed");
    property p_hit_one;
        route_valid && route.smm_hit |-> route.dram ^ route.hub;
    endproperty
    a_hit_one: assert property (p_hit_one)
        else $error("window hit needs one target");
    property p_no_hit;
        route_valid && !route.smm_hit |-> !route.dram && !route.hub;
    endproperty
    a_no_hit: assert property (p_no_hit)
        else $error("target flag outside windows");
    property p_remap;
        host_valid && host_req.addr[31:17] == 15'h7F6D |=> !route.dram
            || route.dram_addr == {15'h0005, $past(host_req.addr[16:0])};
    endproperty
    a_remap: assert property (p_remap)
        else $error("high window remap wrong");
    property p_compat;
        host_valid && host_req.addr[31:17] == 15'h0005
            |=> route.dram_addr == $past(host_req.addr);
    endproperty
    a_compat: assert property (p_compat)
        else $error("compatible window remapped");
    property p_hub_acc;
        hub_valid && hub_addr[31:17] != 15'h0005 |=> hub_accept && !hub_refuse;
    endproperty
    a_hub_acc: assert property (p_hub_acc)
        else $error("hub access outside window refused");
    property p_hub_one;
        hub_valid |=> hub_refuse ^ hub_accept;
    endproperty
    a_hub_one: assert property (p_hub_one)
        else $error("hub access needs one answer");
    property p_lock;
        smm_space_locked_out |=> smm_space_locked_out;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock dropped without reset");
endmodule : srac_core_props

bind srac_core srac_core_props u_props (.clk, .rstn, .cfg_rd, .cfg_rvalid,
    .host_valid, .host_req, .route_valid, .route, .hub_valid, .hub_addr,
    .hub_refuse, .hub_accept, .smm_space_locked_out);

//--- srac_far_model.sv
// Purpose: processor host bus and hub interface requester
// Assumes: answers come one cycle after the request
// Notes:   idle lines carry the inverse of the last value
`timescale 1ns/10ps
module srac_far_model
    import srac_pkg::*;
(
    input  wire logic        clk,
    output logic             host_valid,
    output srac_host_req_t   host_req,
    input  wire logic        route_valid,
    input  wire srac_route_t route,
    output logic             hub_valid,
    output logic [31:0]      hub_addr,
    input  wire logic        hub_refuse,
    input  wire logic        hub_accept
);
    // ****
    // requests
    // ****
    logic [35:0] seen;
    logic [1:0]  hub_seen;
    initial
    begin
        host_valid = 1'b0;
        host_req   = '0;
        hub_valid  = 1'b0;
        hub_addr   = '0;
    end
    task host(input logic [31:0] a, input logic s, input logic c);
        @(negedge clk);
        host_valid = 1'b1;
        host_req   = '{addr: a, smm: s, code: c, write: 1'b0};
        @(negedge clk);
        host_valid = 1'b0;
        host_req   = ~host_req;
        seen       = {route_valid, route};
    endtask : host
    task hub(input logic [31:0] a);
        @(negedge clk);
        hub_valid = 1'b1;
        hub_addr  = a;
        @(negedge clk);
        hub_valid = 1'b0;
        hub_addr  = ~a;
        hub_seen  = {hub_refuse, hub_accept};
    endtask : hub
endmodule : srac_far_model

//--- srac_pkg.sv
// Purpose: shared constants and carriers of the smm ram access control
// Assumes: 32-bit physical host addresses, 8-bit configuration registers
// Notes:   every offset, field position and reset value lives here
package srac_pkg;

    // ****************************************
    // configuration space
    // ****************************************
    localparam logic [7:0] SRAC_CTRL_OFS     = 8'h60;
    localparam logic [7:0] SRAC_EXT_OFS      = 8'h61;
    localparam logic [7:0] SRAC_CTRL_RESET   = 8'h02;
    localparam logic [7:0] SRAC_EXT_RESET    = 8'h38;

    // control register fields
    localparam int         SRAC_OPEN_BIT     = 6;
    localparam int         SRAC_CLOSE_BIT    = 5;
    localparam int         SRAC_LOCK_BIT     = 4;
    localparam int         SRAC_GLOBAL_BIT   = 3;
    localparam logic [2:0] SRAC_BASE_SEG     = 3'h2;

    // extended register fields
    localparam int         SRAC_HIGH_BIT     = 7;
    localparam int         SRAC_VIOL_BIT     = 6;
    localparam int         SRAC_CACHE_BIT    = 5;
    localparam int         SRAC_L1_BIT       = 4;
    localparam int         SRAC_L2_BIT       = 3;
    localparam int         SRAC_TSEG_BIT     = 0;

    // ****************************************
    // address windows
    // ****************************************
    localparam logic [31:0] SRAC_COMPAT_BASE = 32'h000A_0000;
    localparam logic [31:0] SRAC_HIGH_BASE   = 32'hFEDA_0000;
    localparam int          SRAC_WIN_BITS    = 17;
    localparam int          SRAC_TSEG_BITS   = 20;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [31:0] addr;
        logic        smm;
        logic        code;
        logic        write;
    } srac_host_req_t;

    typedef struct packed {
        logic        smm_hit;
        logic        dram;
        logic        hub;
        logic [31:0] dram_addr;
    } srac_route_t;

endpackage : srac_pkg

//--- srac_range_match.sv
// Purpose: aligned power-of-two address window compare
// Assumes: base is aligned to the window size
// Notes:   purely combinational
`timescale 1ns/10ps
module srac_range_match
    import srac_pkg::*;
#(
    parameter int SIZE_BITS = 17
)
(
    input  wire logic [31:0] addr,
    input  wire logic [31:0] base,
    output logic             hit
);

    assign hit = (addr[31:SIZE_BITS] == base[31:SIZE_BITS]);

endmodule : srac_range_match

//--- srac_sticky_flag.sv
// Purpose: sticky status bit, set by hardware, cleared by software
// Assumes: set and clear are single-cycle strobes
// Notes:   a set in the clearing cycle wins
`timescale 1ns/10ps
module srac_sticky_flag
    import srac_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic set,
    input  wire logic clear,
    output logic      q
);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q <= 1'b0;
        else if (set)
            q <= 1'b1;
        else if (clear)
            q <= 1'b0;
    end

endmodule : srac_sticky_flag

//--- tb_top.sv
// Purpose: self-checking bench for srac_core
// Assumes: far model issues host and hub requests
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
module tb_top
    import srac_pkg::*;
;
    logic           clk;
    logic           rstn;
    logic           cfg_wr;
    logic           cfg_rd;
    logic [7:0]     cfg_addr;
    logic [7:0]     cfg_wdata;
    logic [7:0]     cfg_rdata;
    logic           cfg_rvalid;
    logic           host_valid;
    srac_host_req_t host_req;
    logic [31:0]    tseg_base;
    logic           route_valid;
    srac_route_t    route;
    logic           hub_valid;
    logic [31:0]    hub_addr;
    logic           hub_refuse;
    logic           hub_accept;
    logic           smm_space_locked_out;
    logic [8:0]     rdv;
    int             err_count;
    int             checks_done;

    srac_core dut (.clk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
        .cfg_rdata, .cfg_rvalid, .host_valid, .host_req, .tseg_base,
        .route_valid, .route, .hub_valid, .hub_addr, .hub_refuse,
        .hub_accept, .smm_space_locked_out);
    srac_far_model far (.clk, .host_valid, .host_req, .route_valid, .route,
        .hub_valid, .hub_addr, .hub_refuse, .hub_accept);

    always #2.5 clk = ~clk;

    // ****
    // helpers
    // ****
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task cw(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_wr    = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr    = 1'b0;
        cfg_addr  = ~a;
        cfg_wdata = ~d;
    endtask : cw
    task cr(input logic [7:0] a);
        @(negedge clk);
        cfg_rd   = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd   = 1'b0;
        cfg_addr = ~a;
        rdv      = {cfg_rvalid, cfg_rdata};
    endtask : cr
    task do_reset;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
    endtask : do_reset
    task close_out;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // ****
    // scenarios
    // ****
    task t_defaults;
        cr(8'h60);
        chk(rdv, {1'b1, 8'h02});
        cr(8'h61);
        chk(rdv, {1'b1, 8'h38});
        cr(8'h70);
        chk(rdv, {1'b1, 8'h00});
        cw(8'h60, 8'h70);
        cr(8'h60);
        chk(rdv, {1'b1, 8'h02});
        far.host(32'h000A_1234, 1'b1, 1'b0);
        chk(far.seen, {4'h8, 32'h000A_1234});
        cw(8'h61, 8'h81);
        far.host(32'hFEDA_1234, 1'b1, 1'b0);
        chk(far.seen, {4'h8, 32'hFEDA_1234});
        far.host(32'h1000_0000, 1'b1, 1'b0);
        chk(far.seen, {4'h8, 32'h1000_0000});
        far.hub(32'h000B_0000);
        chk(far.hub_seen, 2'b01);
    endtask : t_defaults
    task t_open_close;
        cw(8'h60, 8'h08);
        far.host(32'h000A_1234, 1'b1, 1'b0);
        chk(far.seen, {4'hE, 32'h000A_1234});
        far.host(32'h000B_FFFF, 1'b0, 1'b0);
        chk(far.seen, {4'hD, 32'h000B_FFFF});
        far.hub(32'h000B_0000);
        chk(far.hub_seen, 2'b10);
        far.hub(32'h000C_0000);
        chk(far.hub_seen, 2'b01);
        cw(8'h60, 8'h48);
        far.host(32'h000A_0010, 1'b0, 1'b0);
        chk(far.seen, {4'hE, 32'h000A_0010});
        cw(8'h60, 8'h68);
        cr(8'h60);
        chk(rdv, {1'b1, 8'h6A});
        far.host(32'h000A_0010, 1'b0, 1'b0);
        chk(far.seen, {4'hD, 32'h000A_0010});
        cw(8'h60, 8'h28);
        far.host(32'h000A_0010, 1'b1, 1'b0);
        chk(far.seen, {4'hD, 32'h000A_0010});
        far.host(32'h000A_0010, 1'b1, 1'b1);
        chk(far.seen, {4'hE, 32'h000A_0010});
        cw(8'h60, 8'h08);
    endtask : t_open_close
    task t_extended;
        cw(8'h61, 8'h81);
        cr(8'h61);
        chk(rdv, {1'b1, 8'hB9});
        far.host(32'hFEDA_1234, 1'b1, 1'b0);
        chk(far.seen, {4'hE, 32'h000A_1234});
        far.host(32'h100F_FFFC, 1'b1, 1'b0);
        chk(far.seen, {4'hE, 32'h100F_FFFC});
        far.host(32'h1010_0000, 1'b1, 1'b0);
        chk(far.seen, {4'h8, 32'h1010_0000});
        far.host(32'h1000_0000, 1'b0, 1'b0);
        cr(8'h61);
        chk(rdv, {1'b1, 8'hF9});
        cw(8'h61, 8'hC1);
        cr(8'h61);
        chk(rdv, {1'b1, 8'hB9});
    endtask : t_extended
    task t_lock;
        cw(8'h60, 8'h18);
        chk(smm_space_locked_out, 1'b1);
        cw(8'h60, 8'h48);
        cr(8'h60);
        chk(rdv, {1'b1, 8'h1A});
        cw(8'h60, 8'h28);
        cr(8'h60);
        chk(rdv, {1'b1, 8'h3A});
        cw(8'h60, 8'h00);
        cr(8'h60);
        chk(rdv, {1'b1, 8'h1A});
        cw(8'h61, 8'h00);
        cr(8'h61);
        chk(rdv, {1'b1, 8'hB9});
        far.host(32'h000A_0010, 1'b0, 1'b0);
        chk(far.seen, {4'hD, 32'h000A_0010});
        do_reset;
        cr(8'h60);
        chk(rdv, {1'b1, 8'h02});
        chk(smm_space_locked_out, 1'b0);
    endtask : t_lock

    initial
    begin
        clk         = 1'b0;
        rstn        = 1'b0;
        cfg_wr      = 1'b0;
        cfg_rd      = 1'b0;
        cfg_addr    = 8'h00;
        cfg_wdata   = 8'h00;
        tseg_base   = 32'h1000_0000;
        err_count   = 0;
        checks_done = 0;
        do_reset;
        t_defaults;
        t_open_close;
        t_extended;
        t_lock;
        close_out;
    end
    initial
    begin
        #20000;
        err_count++;
        close_out;
    end
endmodule : tb_top
